/* File: core/aovr_pkg.sv */
// Purpose: shared constants and types for the overrange monitor
// Assumes: 12-bit two's complement samples, 32-bit APB data
// Notes: register offsets are byte addresses of aligned words
package aovr_pkg;
    // register byte offsets
    localparam logic [7:0] AOVR_OFS_THRESH = 8'h00;
    localparam logic [7:0] AOVR_OFS_CTRL = 8'h04;
    localparam logic [7:0] AOVR_OFS_STATUS = 8'h08;
    localparam logic [7:0] AOVR_OFS_IRQ_STAT = 8'h0C;
    localparam logic [7:0] AOVR_OFS_IRQ_MASK = 8'h10;
    // thresh register fields
    localparam int AOVR_HIGH_LSB = 8;
    localparam int AOVR_LOW_LSB = 0;
    // ctrl register fields
    localparam int AOVR_HOLD_LSB = 0;
    localparam int AOVR_SINGLE_BIT = 7;
    localparam int AOVR_SEL_B_BIT = 6;
    localparam int AOVR_SWAP_BIT = 5;
    localparam int AOVR_CAL_BIT = 4;
    // reset values
    localparam logic [7:0] AOVR_HIGH_RST = 8'hE4;
    localparam logic [7:0] AOVR_LOW_RST = 8'h40;
    localparam logic [2:0] AOVR_HOLD_RST = 3'h0;
    // hold length: 8 << sel cycles
    localparam int AOVR_HOLD_BASE_LOG2 = 3;
    localparam int AOVR_CNT_W = 11;
    localparam int AOVR_SAMPLE_W = 12;
    localparam int AOVR_MAG_W = 8;
    localparam int AOVR_NFLAG = 4;

    typedef struct packed {
        logic [7:0] high_level_threshold;
        logic [7:0] low_level_threshold;
    } aovr_thresh_t;

    typedef struct packed {
        logic single_mode;
        logic single_sel_b;
        logic dual_swap;
        logic cal_run;
    } aovr_route_t;
endpackage

/* File: core/aovr_hold.sv */
// Purpose: one overrange flag with retriggerable hold counter
// Assumes: hit pulses are already aligned to the sample stream
// Notes: each new hit reloads the count
`timescale 1ns/1ps
module aovr_hold (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic hit,
    input wire logic [2:0] hold_sel,
    output logic flag,
    output logic rise
);
    logic [aovr_pkg::AOVR_CNT_W-1:0] cnt_reg, cnt_next;
    logic flag_reg, flag_next;
    logic [aovr_pkg::AOVR_CNT_W-1:0] load_val;

    // hold length 8,16,...,1024 counted from the latest hit
    always_comb begin
        load_val = aovr_pkg::AOVR_CNT_W'(
            (1 << (aovr_pkg::AOVR_HOLD_BASE_LOG2 + hold_sel)) - 1);
        cnt_next = cnt_reg;
        flag_next = flag_reg;
        if (hit) begin
            cnt_next = load_val; // RL8
            flag_next = 1'b1; // RL4
        end else if (cnt_reg != '0) begin
            cnt_next = cnt_reg - 1'b1;
        end else begin
            flag_next = 1'b0; // RL4
        end
    end

    // state registers only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= '0;
            flag_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            flag_reg <= flag_next;
        end
    end

    assign flag = flag_reg;
    assign rise = hit & ~flag_reg;
endmodule // aovr_hold

/* File: core/aovr_monitor.sv */
// Purpose: overrange monitor with input routing, APB registers, interrupt
// Assumes: samples arrive per channel on pclk, two per edge pair modelled
//          as rise and fall lanes in single-channel mode
// Notes: analog capture is modelled by digital sample ports
//        flags and data share one two-edge pipe, so a receiver can
//        line a flag up with its sample without extra delay
//        writes to the status word are dropped without an error
//        a new hold length applies from the next hit onwards
//
// How it works
// [RL1] take magnitude of each 12-bit sample, compare its upper eight bits
// [RL2] most negative sample saturates to magnitude 2047, upper bits 255
// [RL3] both channels share the high and low thresholds in dual mode
// [RL4] flag is one when magnitude reaches threshold, else zero
// [RL5] dual mode: each channel gives high flag and low flag
// [RL6] single mode: lanes split over A and B outputs of same index
// [RL7] receiver ORs A and B outputs of same index in single mode
// [RL8] flag holds 8 to 1024 cycles after latest event, restarting
// [RL9] samples are signed two's complement, negative when minus input wins
// [RL10] dual mode samples rising edge only; single uses both edges
// [RL11] dual mode two-way interleave per channel; single four-way
// [RL12] single mode field picks input A or B
// [RL13] dual mode field swaps the two inputs between channels
// [RL14] calibration stops sampling and marks output invalid
// [RL15] thresholds eight bits, hold select three bits 0 to 7
// [RL16] flags registered on pclk with fixed latency from capture
`timescale 1ns/1ps
module aovr_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // converted codes of the two inputs, rise and fall lanes each
    input wire logic [11:0] analog_input_a_rise,
    input wire logic [11:0] analog_input_a_fall,
    input wire logic [11:0] analog_input_b_rise,
    input wire logic [11:0] analog_input_b_fall,
    output logic [11:0] chan_a_data,
    output logic [11:0] chan_b_data,
    output logic data_valid,
    output logic chan_a_high_flag,
    output logic chan_a_low_flag,
    output logic chan_b_high_flag,
    output logic chan_b_low_flag,
    output logic irq
);
    aovr_pkg::aovr_thresh_t thresh_reg, thresh_next;
    aovr_pkg::aovr_route_t input_routing_reg, input_routing_next;
    logic [2:0] flag_hold_length_sel_reg, flag_hold_length_sel_next;
    logic [3:0] irq_stat_reg, irq_stat_next;
    logic [3:0] irq_mask_reg, irq_mask_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;
    logic irq_reg, irq_next;
    logic [11:0] lane_a_reg, lane_a_next;
    logic [11:0] lane_b_reg, lane_b_next;
    logic valid_reg, valid_next;
    logic [11:0] out_a_reg, out_b_reg;
    logic out_valid_reg;
    logic [3:0] hit;
    logic [3:0] flag;
    logic [3:0] rise;
    logic [7:0] mag_a, mag_b;
    logic access;

    // magnitude upper eight bits; -2048 saturates to 2047
    // -2048 has no positive twin in twelve bits, hence the saturation
    function automatic logic [7:0] mag8(input logic [11:0] s);
        logic [10:0] m;
        m = '0;
        if (s == 12'h800) begin
            m = 11'h7FF; // RL2
        end else if (s[11]) begin
            m = 11'((~s) + 12'h001); // RL1
        end else begin
            m = s[10:0]; // RL1
        end
        return m[10:3]; // RL1
    endfunction

    // pipeline: the sample ports land in the lane registers on one edge,
    // the compare on the lanes loads the hold cells on the next, and the
    // data copy waits one stage so flags and samples leave together;
    // the latency is two edges in every mode and routing setting
    // routing and capture: dual uses rise lanes only, single alternates
    // rise and fall lanes of the chosen input across the A and B outputs
    // calibration freezes the lanes, so the last sample stays put
    always_comb begin
        lane_a_next = lane_a_reg;
        lane_b_next = lane_b_reg;
        valid_next = 1'b0;
        if (input_routing_reg.cal_run) begin
            valid_next = 1'b0; // RL14
        end else if (input_routing_reg.single_mode) begin
            // both edges captured, four-way interleave of cores RL10 RL11
            valid_next = 1'b1; // RL10 RL11
            if (input_routing_reg.single_sel_b) begin
                lane_a_next = analog_input_b_rise; // RL12
                lane_b_next = analog_input_b_fall; // RL12
            end else begin
                lane_a_next = analog_input_a_rise; // RL12
                lane_b_next = analog_input_a_fall; // RL12
            end
        end else begin
            valid_next = 1'b1; // RL10 RL11
            if (input_routing_reg.dual_swap) begin
                lane_a_next = analog_input_b_rise; // RL13
                lane_b_next = analog_input_a_rise; // RL13
            end else begin
                lane_a_next = analog_input_a_rise;
                lane_b_next = analog_input_b_rise;
            end
        end
    end

    // threshold compare on the captured lanes, shared thresholds
    // both channels read one register pair, so a write retunes A and B
    // together; the compare is unsigned on the eight magnitude bits
    always_comb begin
        mag_a = mag8(lane_a_reg);
        mag_b = mag8(lane_b_reg);
        hit[0] = valid_reg &&
            (mag_a >= thresh_reg.high_level_threshold); // RL3 RL4 RL5
        hit[1] = valid_reg &&
            (mag_a >= thresh_reg.low_level_threshold); // RL3 RL4 RL5
        hit[2] = valid_reg &&
            (mag_b >= thresh_reg.high_level_threshold); // RL3 RL6
        hit[3] = valid_reg &&
            (mag_b >= thresh_reg.low_level_threshold); // RL3 RL6
    end

    // one hold counter per flag output
    // separate cells keep the flags independent; a shared counter
    // would let a hit on one threshold stretch the other flag
    genvar gi;
    generate
        for (gi = 0; gi < aovr_pkg::AOVR_NFLAG; gi++) begin : g_hold
            aovr_hold u_hold (
                .pclk(pclk),
                .presetn(presetn),
                .hit(hit[gi]),
                .hold_sel(flag_hold_length_sel_reg),
                .flag(flag[gi]),
                .rise(rise[gi])
            );
        end
    endgenerate

    // a transfer completes at the edge that sees pready high
    assign access = psel && penable && pready_reg;

    // register map, one aligned word each:
    //   0x00 thresholds: [7:0] low level, [15:8] high level
    //   0x04 control: [2:0] hold length select, [4] calibration run,
    //        [5] dual swap, [6] single input b, [7] single-channel mode
    //   0x08 status, read only: [3:0] flags, [4] data valid
    //   0x0C interrupt status: set on a flag rise, write one to clear
    //   0x10 interrupt mask, same layout as interrupt status
    //   any other offset answers pslverr and reads as zero
    // the wait state gives the read mux a full cycle; the cost is one
    // extra cycle per access, which software polling never notices
    // apb slave: one wait state, answer on second access cycle
    always_comb begin
        thresh_next = thresh_reg;
        input_routing_next = input_routing_reg;
        flag_hold_length_sel_next = flag_hold_length_sel_reg;
        irq_mask_next = irq_mask_reg;
        prdata_next = prdata_reg;
        pslverr_next = 1'b0;
        pready_next = psel && penable && !pready_reg;
        // set wins over a write-one clear in the same cycle
        // a flag that rises while its clear is written stays pending
        irq_stat_next = irq_stat_reg;
        if (access && pwrite && paddr == aovr_pkg::AOVR_OFS_IRQ_STAT) begin
            irq_stat_next = irq_stat_reg & ~pwdata[3:0];
        end
        irq_stat_next = irq_stat_next | rise;
        if (psel && penable && !pready_reg) begin
            prdata_next = 32'h0000_0000;
            case (paddr)
                aovr_pkg::AOVR_OFS_THRESH: begin
                    prdata_next[aovr_pkg::AOVR_HIGH_LSB +: 8] =
                        thresh_reg.high_level_threshold;
                    prdata_next[aovr_pkg::AOVR_LOW_LSB +: 8] =
                        thresh_reg.low_level_threshold;
                end
                aovr_pkg::AOVR_OFS_CTRL: begin
                    prdata_next[aovr_pkg::AOVR_HOLD_LSB +: 3] =
                        flag_hold_length_sel_reg; // RL15
                    prdata_next[aovr_pkg::AOVR_SINGLE_BIT] =
                        input_routing_reg.single_mode;
                    prdata_next[aovr_pkg::AOVR_SEL_B_BIT] =
                        input_routing_reg.single_sel_b;
                    prdata_next[aovr_pkg::AOVR_SWAP_BIT] =
                        input_routing_reg.dual_swap;
                    prdata_next[aovr_pkg::AOVR_CAL_BIT] =
                        input_routing_reg.cal_run;
                end
                aovr_pkg::AOVR_OFS_STATUS: begin
                    prdata_next[3:0] = flag;
                    prdata_next[4] = out_valid_reg;
                end
                aovr_pkg::AOVR_OFS_IRQ_STAT: begin
                    prdata_next[3:0] = irq_stat_reg;
                end
                aovr_pkg::AOVR_OFS_IRQ_MASK: begin
                    prdata_next[3:0] = irq_mask_reg;
                end
                default: begin
                    pslverr_next = 1'b1;
                end
            endcase
        end
        if (access && pwrite) begin
            case (paddr)
                aovr_pkg::AOVR_OFS_THRESH: begin
                    thresh_next.high_level_threshold =
                        pwdata[aovr_pkg::AOVR_HIGH_LSB +: 8]; // RL15
                    thresh_next.low_level_threshold =
                        pwdata[aovr_pkg::AOVR_LOW_LSB +: 8]; // RL15
                end
                aovr_pkg::AOVR_OFS_CTRL: begin
                    flag_hold_length_sel_next =
                        pwdata[aovr_pkg::AOVR_HOLD_LSB +: 3]; // RL15
                    input_routing_next.single_mode =
                        pwdata[aovr_pkg::AOVR_SINGLE_BIT];
                    input_routing_next.single_sel_b =
                        pwdata[aovr_pkg::AOVR_SEL_B_BIT];
                    input_routing_next.dual_swap =
                        pwdata[aovr_pkg::AOVR_SWAP_BIT];
                    input_routing_next.cal_run =
                        pwdata[aovr_pkg::AOVR_CAL_BIT];
                end
                aovr_pkg::AOVR_OFS_IRQ_MASK: begin
                    irq_mask_next = pwdata[3:0];
                end
                default: begin
                end
            endcase
        end
        irq_next = |(irq_stat_next & irq_mask_next);
    end

    // state registers
    // the data copy stage matches the cycle spent in the hold cells
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            thresh_reg <= {aovr_pkg::AOVR_HIGH_RST, aovr_pkg::AOVR_LOW_RST};
            input_routing_reg <= '0;
            flag_hold_length_sel_reg <= aovr_pkg::AOVR_HOLD_RST;
            irq_stat_reg <= '0;
            irq_mask_reg <= '0;
            prdata_reg <= '0;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            irq_reg <= 1'b0;
            lane_a_reg <= '0;
            lane_b_reg <= '0;
            valid_reg <= 1'b0;
            out_a_reg <= '0;
            out_b_reg <= '0;
            out_valid_reg <= 1'b0;
        end else begin
            thresh_reg <= thresh_next;
            input_routing_reg <= input_routing_next;
            flag_hold_length_sel_reg <= flag_hold_length_sel_next;
            irq_stat_reg <= irq_stat_next;
            irq_mask_reg <= irq_mask_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            irq_reg <= irq_next;
            lane_a_reg <= lane_a_next;
            lane_b_reg <= lane_b_next;
            valid_reg <= valid_next;
            // data delayed one stage so it lines up with the flags
            out_a_reg <= lane_a_reg; // RL9 RL16
            out_b_reg <= lane_b_reg; // RL9 RL16
            out_valid_reg <= valid_reg; // RL14 RL16
        end
    end

    // bus and stream outputs come straight from their registers
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign irq = irq_reg;
    assign chan_a_data = out_a_reg;
    assign chan_b_data = out_b_reg;
    assign data_valid = out_valid_reg;
    // flags already registered in the hold cells RL16
    // the hold cells end in flops, so no logic sits behind these pins
    assign chan_a_high_flag = flag[0]; // RL5
    assign chan_a_low_flag = flag[1]; // RL5
    assign chan_b_high_flag = flag[2]; // RL5 RL6
    assign chan_b_low_flag = flag[3]; // RL5 RL6
endmodule // aovr_monitor

/* File: verif/aovr_monitor_props.sv */
// Purpose: port checks for the overrange monitor
// Assumes: one wait state per access, flags held 8 cycles at least
// Notes: bound from the bench top file
`timescale 1ns/1ps
module aovr_monitor_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic data_valid,
    input wire logic chan_a_high_flag,
    input wire logic chan_b_low_flag
);
    default clocking dc @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // bus answer timing and refusal
    a_apb_wait: assert property (psel && !penable |=> !pready ##1 pready)
        else $error("answer not on second edge");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_unmapped_err: assert property (pready && paddr[7:5] != 3'h0
        |-> pslverr && prdata == 32'h0) else $error("unmapped not refused");
    a_mapped_ok: assert property (pready && paddr <= 8'h10
        && paddr[1:0] == 2'h0 |-> !pslverr) else $error("mapped refused");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    // the shortest hold is 8 cycles, so any rise stays up that long
    a_hold_a_high: assert property ($rose(chan_a_high_flag)
        |=> chan_a_high_flag [*7]) else $error("high flag fell early");
    a_hold_b_low: assert property ($rose(chan_b_low_flag)
        |=> chan_b_low_flag [*7]) else $error("low flag fell early");
    // flags ride the data pipe, so a rise needs valid data beside it
    a_flag_valid: assert property ($rose(chan_a_high_flag)
        |-> data_valid) else $error("flag without valid data");
endmodule // aovr_monitor_props

/* File: verif/aovr_gain_model.sv */
// Purpose: downstream gain logic reading the overrange flags
// Assumes: flags are levels on the device clock
// Notes: kept combinational; a real receiver would register them
`timescale 1ns/1ps
module aovr_gain_model (
    input wire logic single_mode,
    input wire logic chan_a_high_flag,
    input wire logic chan_a_low_flag,
    input wire logic chan_b_high_flag,
    input wire logic chan_b_low_flag,
    output logic over_high,
    output logic over_low
);
    // single mode spreads one threshold over both sides, so join them
    assign over_high = chan_a_high_flag
        | (single_mode & chan_b_high_flag);
    assign over_low = chan_a_low_flag
        | (single_mode & chan_b_low_flag);
endmodule // aovr_gain_model

/* File: verif/aovr_monitor_test.sv */
// Purpose: self-checking bench for the overrange monitor
// Assumes: one wait state apb, flags two edges after a sample
// Notes: the full hold sweep keeps the run near 2400 cycles
`timescale 1ns/1ps
module aovr_monitor_test;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic sng = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, dv, irq, ah, al, bh, bl, oh, ol;
    logic [11:0] da, db;
    logic [11:0] ln [4] = '{default: 12'h000};
    logic [11:0] smp [7] = '{12'h7FF, 12'h7F0, 12'h7EF, 12'h800, 12'h810,
        12'h811, 12'h000};
    logic [1:0] ex [7] = '{2'h3, 2'h3, 2'h1, 2'h3, 2'h3, 2'h1, 2'h0};
    logic [7:0] cv [9] = '{8'h00, 8'h00, 8'h20, 8'h20, 8'h80, 8'h80,
        8'h80, 8'hC0, 8'h10};
    int lv [9] = '{2, 1, 0, 2, 0, 1, 2, 3, 0};
    logic [3:0] fv [9] = '{4'h3, 4'h0, 4'h3, 4'hC, 4'hC, 4'h3, 4'h0,
        4'h3, 4'h0};
    int n_mismatch = 0;
    int n_checks = 0;
    int n;
    // 20 MHz device clock
    always #25 pclk = ~pclk;
    aovr_monitor aovr_monitor_i (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .analog_input_a_rise(ln[0]),
        .analog_input_a_fall(ln[1]), .analog_input_b_rise(ln[2]),
        .analog_input_b_fall(ln[3]), .chan_a_data(da), .chan_b_data(db),
        .data_valid(dv), .chan_a_high_flag(ah), .chan_a_low_flag(al),
        .chan_b_high_flag(bh), .chan_b_low_flag(bl), .irq(irq));
    aovr_gain_model aovr_gain_model_i (.single_mode(sng),
        .chan_a_high_flag(ah), .chan_a_low_flag(al),
        .chan_b_high_flag(bh), .chan_b_low_flag(bl),
        .over_high(oh), .over_low(ol));
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one transfer; waits for the answer rather than a fixed count
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        chk(pready, 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // one-cycle sample on a lane; returns once the flags have landed
    task automatic send(input int i, input logic [11:0] s);
        @(posedge pclk);
        ln[i] <= s;
        @(posedge pclk);
        ln[i] <= 12'h000;
        @(posedge pclk);
        #1;
    endtask
    // cycles the channel a high flag stays up
    task automatic hold(output int c);
        c = 0;
        while (ah === 1'b1 && c < 1100) begin
            @(posedge pclk);
            #1;
            c++;
        end
    endtask
    task automatic final_report();
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h0000E440);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk(err, 1'b1);
        chk(rd, 32'h0);
        apb(1'b1, 8'h00, 32'h0000FE40);
        // magnitude corners against high 254 and low 64
        for (int i = 0; i < 7; i++) begin
            send(0, smp[i]);
            chk({ah, al}, ex[i]);
            chk(da, smp[i]);
            chk(dv, 1'b1);
            repeat (10) @(posedge pclk);
        end
        // only channel a flags rose: mask, raise, clear
        apb(1'b0, 8'h0C, 32'h0);
        chk(rd, 32'h3);
        chk(irq, 1'b0);
        apb(1'b1, 8'h10, 32'h3);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b1);
        apb(1'b1, 8'h0C, 32'h3);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b0);
        // routing per mode, swap, input choice and calibration
        for (int i = 0; i < 9; i++) begin
            apb(1'b1, 8'h04, {24'h0, cv[i]});
            sng <= cv[i][7];
            send(lv[i], 12'h7FF);
            chk({ah, al, bh, bl}, fv[i]);
            chk(dv, !cv[i][4]);
            chk(oh, fv[i][3] | (cv[i][7] & fv[i][1]));
            chk(ol, fv[i][2] | (cv[i][7] & fv[i][0]));
            chk(da, fv[i][3] ? 12'h7FF : 12'h000);
            chk(db, fv[i][1] ? 12'h7FF : 12'h000);
            repeat (10) @(posedge pclk);
        end
        // every hold length; a second hit restarts the shortest one
        for (int s = 0; s < 8; s++) begin
            apb(1'b1, 8'h04, 32'(s));
            send(0, 12'h7FF);
            if (s == 0) send(0, 12'h7FF);
            hold(n);
            chk(n, 8 << s);
        end
        apb(1'b1, 8'h40, 32'h3);
        chk(err, 1'b1);
        apb(1'b1, 8'h08, 32'h1F);
        apb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h10);
        final_report();
    end
    // tests need about 120 us; a hang is cut well after that
    initial begin
        #1ms;
        n_mismatch++;
        final_report();
    end
endmodule // aovr_monitor_test

bind aovr_monitor aovr_monitor_props aovr_monitor_props_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .data_valid(data_valid), .chan_a_high_flag(chan_a_high_flag),
    .chan_b_low_flag(chan_b_low_flag));
